/* File: scc_pkg.sv */
package scc_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TUNE = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_CLK_STAT = 8'h10;

    // Oscillator control field positions
    localparam int CTRL_IDLE_BIT = 7;
    localparam int CTRL_FREQ_LSB = 4;
    localparam int CTRL_PRIMARY_STARTUP_DONE_BIT = 3;
    localparam int CTRL_STABLE_BIT = 2;
    localparam int CTRL_SRC_LSB = 0;

    // Oscillator tuning field positions
    localparam int TUNE_LOWSRC_BIT = 7;
    localparam int TUNE_MULT_BIT = 6;
    localparam int TUNE_TRIM_LSB = 0;

    // Values after reset
    localparam logic [2:0] FREQ_RESET = 3'h4;
    localparam logic [1:0] SRC_SEL_RESET = 2'h0;
    localparam logic [5:0] TRIM_RESET = 6'h00;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    // Clock source select codes
    localparam logic [1:0] SEL_INTERNAL = 2'h3;
    localparam logic [1:0] SEL_PRIMARY = 2'h2;
    localparam logic [1:0] SEL_SECONDARY = 2'h1;

    // Frequency select code that routes the low-frequency source
    localparam logic [2:0] FREQ_LOW = 3'h0;

    // Oscillator modes that carry the multiplier
    localparam logic [2:0] MODE_CRYSTAL_MULT = 3'h4;
    localparam logic [2:0] MODE_EXTCLK_MULT = 3'h6;

    // Pause lengths of a source switch, in edges of the old and new source
    localparam logic [2:0] PAUSE_OLD_EDGES = 3'h2;
    localparam logic [2:0] PAUSE_NEW_EDGES = 3'h4;

    // Interrupt event bits
    localparam int EV_SWITCH_DONE = 0;
    localparam int EV_PRIMARY_UP = 1;
    localparam int EV_FAST_STABLE = 2;
    localparam int EV_SEC_REFUSED = 3;

    // Active source codes
    typedef enum logic [1:0] {
        SCC_SRC_PRIMARY = 2'h0,
        SCC_SRC_SECONDARY = 2'h1,
        SCC_SRC_INTERNAL = 2'h2
    } scc_src_t;

    typedef enum logic [2:0] {
        SCC_ST_RUN = 3'b001,
        SCC_ST_OLD = 3'b010,
        SCC_ST_NEW = 3'b100
    } scc_state_t;

endpackage

/* File: scc_sync.sv */
`timescale 1ns/100ps
module scc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic sysRst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] nxt_syncOut;

    // A bit is accepted only once the last two stages agree
    assign nxt_syncOut = (stage3_ff & ~(stage2_ff ^ stage3_ff))
                         | (syncOut & (stage2_ff ^ stage3_ff));

    always_ff @(posedge clk) begin
        if (sysRst) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
            syncOut <= '0;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            syncOut <= nxt_syncOut;
        end
    end

endmodule

/* File: scc_top.sv */
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
module scc_top (
    input wire logic clk,
    input wire logic sysRst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [2:0] oscModeConfig,
    input wire logic defaultSourceConfig,
    input wire logic twoSpeedStartupConfig,
    input wire logic startupTimerDone,
    input wire logic fastRcStableIn,
    input wire logic secondaryOscEnable,
    input wire logic [3:0] srcClkToggle,
    input wire logic sleepReq,
    input wire logic wakeReq,
    output logic [1:0] activeSource,
    output logic deviceClockRun,
    output logic [2:0] fastRcFreqSelect,
    output logic [5:0] fastRcTrim,
    output logic lowFreqSourceSelect,
    output logic multiplierEnable,
    output logic idleActive,
    output logic sleepActive,
    output logic primaryStartupDone,
    output logic secondaryClockRunning,
    output logic slowRcRun,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Source select to the source it names
    function automatic scc_pkg::scc_src_t decodeSource(input logic [1:0] sel, input logic defCfg);
        scc_pkg::scc_src_t res;
        res = scc_pkg::SCC_SRC_INTERNAL;
        if (sel == scc_pkg::SEL_PRIMARY) begin
            res = scc_pkg::SCC_SRC_PRIMARY;
        end else if (sel == scc_pkg::SEL_SECONDARY) begin
            res = scc_pkg::SCC_SRC_SECONDARY;
        end else if (sel == scc_pkg::SRC_SEL_RESET && defCfg) begin
            res = scc_pkg::SCC_SRC_PRIMARY;
        end
        return res;
    endfunction

    // Edge of the given source, internal one split by frequency routing
    function automatic logic sourceEdge(input scc_pkg::scc_src_t src, input logic [3:0] edges,
                                        input logic useSlow);
        logic res;
        res = 1'b0;
        unique case (src)
            scc_pkg::SCC_SRC_PRIMARY: res = edges[0];
            scc_pkg::SCC_SRC_SECONDARY: res = edges[1];
            scc_pkg::SCC_SRC_INTERNAL: res = useSlow ? edges[3] : edges[2];
            default: res = 1'b0;
        endcase
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [6:0] pinSync;
    logic [3:0] srcPrev_ff;
    logic [3:0] srcEdges;
    logic primaryReady;
    logic fastStable;
    logic secEnabled;

    scc_sync #(.WIDTH(7)) u_sync (
        .clk(clk),
        .sysRst(sysRst),
        .asyncIn({secondaryOscEnable, fastRcStableIn, startupTimerDone, srcClkToggle}),
        .syncOut(pinSync)
    );

    assign srcEdges = pinSync[3:0] ^ srcPrev_ff;
    assign primaryReady = pinSync[4];
    assign fastStable = pinSync[5];
    assign secEnabled = pinSync[6];

    ////////////////////////////////////////////////////////////////////////
    // Bus slave

    logic addrPhase;
    logic wrPend_ff;
    logic rdPend_ff;
    logic [7:0] addr_ff;
    logic [7:0] regAddr;
    logic wrCtrl;
    logic wrTune;
    logic wrStat;
    logic wrMask;
    logic [31:0] rdData;

    // Reads take one wait state so that a write just before is seen
    assign addrPhase = hsel && htrans[1] && hready && hreadyout;
    assign regAddr = addr_ff;
    assign wrCtrl = wrPend_ff && regAddr == scc_pkg::OFS_CTRL;
    assign wrTune = wrPend_ff && regAddr == scc_pkg::OFS_TUNE;
    assign wrStat = wrPend_ff && regAddr == scc_pkg::OFS_IRQ_STAT;
    assign wrMask = wrPend_ff && regAddr == scc_pkg::OFS_IRQ_MASK;

    always_ff @(posedge clk) begin
        if (sysRst) begin
            wrPend_ff <= 1'b0;
            rdPend_ff <= 1'b0;
            addr_ff <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            wrPend_ff <= addrPhase && hwrite;
            rdPend_ff <= addrPhase && !hwrite;
            hreadyout <= !(addrPhase && !hwrite);
            hresp <= 1'b0;
            if (addrPhase) begin
                addr_ff <= haddr[7:0];
            end
            if (rdPend_ff) begin
                hrdata <= rdData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and tuning registers

    logic idleSel_ff;
    logic [1:0] srcSel_ff;
    logic lowSrc_ff;
    logic multEn_ff;
    logic multAllowed;
    logic useSlow;

    // Multiplier bit exists only in the two multiplied modes
    assign multAllowed = oscModeConfig == scc_pkg::MODE_CRYSTAL_MULT
                         || oscModeConfig == scc_pkg::MODE_EXTCLK_MULT;
    // Lowest rate comes from the slow RC unless the divided fast RC is chosen
    assign useSlow = fastRcFreqSelect == scc_pkg::FREQ_LOW && !lowFreqSourceSelect;

    always_ff @(posedge clk) begin
        if (sysRst) begin
            idleSel_ff <= 1'b0;
            fastRcFreqSelect <= scc_pkg::FREQ_RESET;
            srcSel_ff <= scc_pkg::SRC_SEL_RESET;
            lowSrc_ff <= 1'b0;
            multEn_ff <= 1'b0;
            fastRcTrim <= scc_pkg::TRIM_RESET;
        end else begin
            if (wrCtrl) begin
                idleSel_ff <= hwdata[scc_pkg::CTRL_IDLE_BIT];
                fastRcFreqSelect <= hwdata[scc_pkg::CTRL_FREQ_LSB +: 3];
                srcSel_ff <= hwdata[scc_pkg::CTRL_SRC_LSB +: 2];
            end
            if (wrTune) begin
                lowSrc_ff <= hwdata[scc_pkg::TUNE_LOWSRC_BIT];
                multEn_ff <= hwdata[scc_pkg::TUNE_MULT_BIT] && multAllowed;
                fastRcTrim <= hwdata[scc_pkg::TUNE_TRIM_LSB +: 6];
            end else if (!multAllowed) begin
                multEn_ff <= 1'b0;
            end
        end
    end

    assign lowFreqSourceSelect = lowSrc_ff;

    ////////////////////////////////////////////////////////////////////////
    // Sleep and idle

    logic secRefused_ff;
    logic secRefuse;
    logic sleeping;

    assign sleeping = idleActive || sleepActive;
    // Secondary choice is dropped at sleep entry if its oscillator is off
    assign secRefuse = sleepReq && !sleeping && decodeSource(srcSel_ff, defaultSourceConfig)
                       == scc_pkg::SCC_SRC_SECONDARY && !secEnabled;

    always_ff @(posedge clk) begin
        if (sysRst) begin
            idleActive <= 1'b0;
            sleepActive <= 1'b0;
            secRefused_ff <= 1'b0;
        end else begin
            if (sleepReq && !sleeping) begin
                idleActive <= idleSel_ff;
                sleepActive <= !idleSel_ff;
            end else if (wakeReq) begin
                idleActive <= 1'b0;
                sleepActive <= 1'b0;
            end
            if (secRefuse) begin
                secRefused_ff <= 1'b1;
            end else if (wrCtrl || wakeReq) begin
                secRefused_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Glitch-free source switch

    scc_pkg::scc_state_t state_ff;
    scc_pkg::scc_state_t nxt_state;
    scc_pkg::scc_src_t curSrc_ff;
    scc_pkg::scc_src_t target;
    scc_pkg::scc_src_t pendSrc_ff;
    logic [2:0] edgeCnt_ff;
    logic [2:0] nxt_edgeCnt;
    logic oldEdge;
    logic newEdge;
    logic switchDone;

    assign target = secRefused_ff ? curSrc_ff : decodeSource(srcSel_ff, defaultSourceConfig);
    assign oldEdge = sourceEdge(curSrc_ff, srcEdges, useSlow);
    assign newEdge = sourceEdge(pendSrc_ff, srcEdges, useSlow);
    assign switchDone = state_ff == scc_pkg::SCC_ST_NEW && newEdge
                        && edgeCnt_ff == scc_pkg::PAUSE_NEW_EDGES - 3'h1;

    always_comb begin
        nxt_state = state_ff;
        nxt_edgeCnt = edgeCnt_ff;
        unique case (state_ff)
            scc_pkg::SCC_ST_RUN: begin
                if (target != curSrc_ff) begin
                    nxt_state = scc_pkg::SCC_ST_OLD;
                    nxt_edgeCnt = 3'h0;
                end
            end
            scc_pkg::SCC_ST_OLD: begin
                if (oldEdge) begin
                    nxt_edgeCnt = edgeCnt_ff + 3'h1;
                    if (edgeCnt_ff == scc_pkg::PAUSE_OLD_EDGES - 3'h1) begin
                        nxt_state = scc_pkg::SCC_ST_NEW;
                        nxt_edgeCnt = 3'h0;
                    end
                end
            end
            scc_pkg::SCC_ST_NEW: begin
                if (newEdge) begin
                    nxt_edgeCnt = edgeCnt_ff + 3'h1;
                end
                if (switchDone) begin
                    nxt_state = scc_pkg::SCC_ST_RUN;
                end
            end
            default: begin
                nxt_state = scc_pkg::SCC_ST_RUN;
                nxt_edgeCnt = 3'h0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sysRst) begin
            state_ff <= scc_pkg::SCC_ST_RUN;
            edgeCnt_ff <= 3'h0;
            curSrc_ff <= scc_pkg::SCC_SRC_INTERNAL;
            pendSrc_ff <= scc_pkg::SCC_SRC_INTERNAL;
            srcPrev_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            edgeCnt_ff <= nxt_edgeCnt;
            srcPrev_ff <= pinSync[3:0];
            if (state_ff == scc_pkg::SCC_ST_RUN && target != curSrc_ff) begin
                pendSrc_ff <= target;
            end
            if (switchDone) begin
                curSrc_ff <= pendSrc_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags and outputs

    logic nxt_primary_startup_done;
    logic nxt_secRun;
    logic oscStable_ff;

    // Only one of the two running flags can be set: both need a settled source
    assign nxt_primary_startup_done = state_ff == scc_pkg::SCC_ST_RUN && curSrc_ff == scc_pkg::SCC_SRC_PRIMARY
                      && primaryReady;
    assign nxt_secRun = state_ff == scc_pkg::SCC_ST_RUN && curSrc_ff == scc_pkg::SCC_SRC_SECONDARY;

    always_ff @(posedge clk) begin
        if (sysRst) begin
            primaryStartupDone <= !twoSpeedStartupConfig;
            oscStable_ff <= 1'b0;
            secondaryClockRunning <= 1'b0;
            activeSource <= 2'h0;
            deviceClockRun <= 1'b0;
            multiplierEnable <= 1'b0;
            slowRcRun <= 1'b1;
        end else begin
            primaryStartupDone <= nxt_primary_startup_done;
            oscStable_ff <= fastStable;
            secondaryClockRunning <= nxt_secRun;
            activeSource <= switchDone ? pendSrc_ff : curSrc_ff;
            deviceClockRun <= nxt_state == scc_pkg::SCC_ST_RUN;
            multiplierEnable <= multEn_ff && multAllowed;
            // Watchdog and clock monitor need the slow RC whatever the source
            slowRcRun <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    logic [3:0] irqStat_ff;
    logic [3:0] irqMask_ff;
    logic [3:0] events;
    logic primPrev_ff;
    logic stablePrev_ff;

    assign events[scc_pkg::EV_SWITCH_DONE] = switchDone;
    assign events[scc_pkg::EV_PRIMARY_UP] = nxt_primary_startup_done && !primPrev_ff;
    assign events[scc_pkg::EV_FAST_STABLE] = fastStable && !stablePrev_ff;
    assign events[scc_pkg::EV_SEC_REFUSED] = secRefuse;

    always_ff @(posedge clk) begin
        if (sysRst) begin
            irqStat_ff <= 4'h0;
            irqMask_ff <= scc_pkg::IRQ_MASK_RESET;
            primPrev_ff <= 1'b0;
            stablePrev_ff <= 1'b0;
            irq <= 1'b0;
        end else begin
            // A new event wins over a clear in the same cycle
            irqStat_ff <= (irqStat_ff & ~(wrStat ? hwdata[3:0] : 4'h0)) | events;
            if (wrMask) begin
                irqMask_ff <= hwdata[3:0];
            end
            primPrev_ff <= nxt_primary_startup_done;
            stablePrev_ff <= fastStable;
            irq <= |(irqStat_ff & irqMask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux

    logic [7:0] ctrlView;
    logic [7:0] tuneView;
    logic [7:0] clkView;

    assign ctrlView = {idleSel_ff, fastRcFreqSelect, primaryStartupDone, oscStable_ff, srcSel_ff};
    assign tuneView = {lowSrc_ff, multiplierEnable, fastRcTrim};
    assign clkView = {2'h0, sleepActive, idleActive, secondaryClockRunning, deviceClockRun, activeSource};

    always_comb begin
        rdData = 32'h0000_0000;
        unique case (regAddr)
            scc_pkg::OFS_CTRL: rdData = {24'h00_0000, ctrlView};
            scc_pkg::OFS_TUNE: rdData = {24'h00_0000, tuneView};
            scc_pkg::OFS_IRQ_STAT: rdData = {28'h000_0000, irqStat_ff};
            scc_pkg::OFS_IRQ_MASK: rdData = {28'h000_0000, irqMask_ff};
            scc_pkg::OFS_CLK_STAT: rdData = {24'h00_0000, clkView};
            default: rdData = 32'h0000_0000;
        endcase
    end

endmodule

/* File: scc_monitor.sv */
`timescale 1ns/100ps
module scc_monitor (
    input wire logic clk,
    input wire logic sysRst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [2:0] oscModeConfig,
    input wire logic twoSpeedStartupConfig,
    input wire logic sleepReq,
    input wire logic wakeReq,
    input wire logic [1:0] activeSource,
    input wire logic deviceClockRun,
    input wire logic [2:0] fastRcFreqSelect,
    input wire logic [5:0] fastRcTrim,
    input wire logic multiplierEnable,
    input wire logic idleActive,
    input wire logic sleepActive,
    input wire logic primaryStartupDone,
    input wire logic secondaryClockRunning,
    input wire logic slowRcRun
);
    default clocking @(posedge clk); endclocking
    default disable iff (sysRst);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_taken;
        hsel && htrans[1] && hready && hreadyout;
    endsequence
    sequence s_read_walk;
        !hreadyout ##1 hreadyout;
    endsequence
    // Pause of four cycles, below the six cycles that six counted source edges need at least
    sequence s_pause;
        !deviceClockRun [*4];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_read_wait: assert property (s_taken ##0 !hwrite |=> s_read_walk)
        else $error("read data phase not one wait state");
    a_write_fast: assert property (s_taken ##0 hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_reset_vals: assert property ($fell(sysRst) |-> fastRcFreqSelect == 3'h4 && fastRcTrim == 6'h00
        && primaryStartupDone == !twoSpeedStartupConfig && activeSource == 2'h0 && !multiplierEnable)
        else $error("wrong value after reset");
    a_slow_run: assert property (!$fell(sysRst) |-> slowRcRun)
        else $error("slow oscillator stopped");
    a_mult_mode: assert property (multiplierEnable |-> oscModeConfig inside {3'h4, 3'h6})
        else $error("multiplier on in plain mode");
    a_flags_excl: assert property ((idleActive || sleepActive) |-> !(primaryStartupDone && secondaryClockRunning))
        else $error("both running flags set");
    a_switch_edge: assert property ($changed(activeSource) |-> $rose(deviceClockRun))
        else $error("source changed outside pause end");
    a_pause_min: assert property ($fell(deviceClockRun) |-> s_pause)
        else $error("switch pause too short");
    a_pause_max: assert property ($fell(deviceClockRun) |-> ##[1:400] deviceClockRun)
        else $error("switch pause never ended");
    a_sleep_mode: assert property (sleepReq && !idleActive && !sleepActive |=> idleActive != sleepActive)
        else $error("sleep request gave no single mode");
    a_wake_clear: assert property (wakeReq |=> !idleActive && !sleepActive)
        else $error("wake left a low power mode");
endmodule
bind scc_top scc_monitor mon_u (.*);

/* File: scc_osc_model.sv */
`timescale 1ns/100ps
module scc_osc_model #(
    parameter int START_NS = 600,
    parameter int STABLE_NS = 900
) (
    output logic [3:0] srcClkToggle,
    output logic startupTimerDone,
    output logic fastRcStableIn
);
    initial begin
        srcClkToggle = 4'h0;
        startupTimerDone = 1'b0;
        fastRcStableIn = 1'b0;
        #(START_NS) startupTimerDone = 1'b1;
    end
    initial #(STABLE_NS) fastRcStableIn = 1'b1;
    ////////////////////////////////////////////////////////////////////////////
    // Sources run free, unrelated to clk and slower than a quarter of it, so a switch always finds them stable
    always #37 srcClkToggle[0] = ~srcClkToggle[0];
    always #61 srcClkToggle[1] = ~srcClkToggle[1];
    always #29 srcClkToggle[2] = ~srcClkToggle[2];
    always #53 srcClkToggle[3] = ~srcClkToggle[3];
endmodule

/* File: system_clock_select_control_bench.sv */
`timescale 1ns/100ps
module system_clock_select_control_bench;
    logic clk, sysRst, hsel, hwrite, hreadyout, hresp, sleepReq, wakeReq, irq;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans, activeSource;
    logic [2:0] hsize, oscModeConfig, fastRcFreqSelect;
    logic defaultSourceConfig, twoSpeedStartupConfig, startupTimerDone, fastRcStableIn, secondaryOscEnable;
    logic [3:0] srcClkToggle;
    logic [5:0] fastRcTrim;
    logic deviceClockRun, lowFreqSourceSelect, multiplierEnable, idleActive, sleepActive;
    logic primaryStartupDone, secondaryClockRunning, slowRcRun;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [1:0] selTbl [6] = '{scc_pkg::SEL_PRIMARY, scc_pkg::SEL_SECONDARY, 2'h0,
        scc_pkg::SEL_INTERNAL, scc_pkg::SEL_SECONDARY, 2'h0};
    logic dfTbl [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    // Active source codes: 0 primary, 1 secondary, 2 internal
    logic [1:0] expTbl [6] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h1, 2'h2};

    scc_top dut_u (.hready(hreadyout), .*);
    scc_osc_model osc_u (.*);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        rdv = hrdata;
        chk({31'h0, hresp}, 32'h0);
        if (n >= 100) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask

    // Bounded wait over the whole pause of a source switch
    task automatic wait_switch;
        int n;
        n = 0;
        while (deviceClockRun !== 1'b0 && n < 8) begin
            @(posedge clk);
            n++;
        end
        while (deviceClockRun !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        if (n >= 600) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        bus(0, scc_pkg::OFS_CTRL, 32'h0);
        chk(rdv, 32'h40);
        bus(0, scc_pkg::OFS_TUNE, 32'h0);
        chk(rdv, 32'h0);
        bus(1, 8'h14, 32'hff);
        bus(0, 8'h14, 32'h0);
        chk(rdv, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_freq;
        for (int c = 0; c < 8; c++) begin
            bus(1, scc_pkg::OFS_CTRL, {25'h0, c[2:0], 4'h3});
            repeat (2) @(posedge clk);
            chk({29'h0, fastRcFreqSelect}, {29'h0, c[2:0]});
            bus(0, scc_pkg::OFS_CTRL, 32'h0);
            chk(rdv & 32'hf3, {25'h0, c[2:0], 4'h3});
        end
        $display("test frequency select done");
    endtask

    task automatic t_tune;
        logic [7:0] e;
        for (int m = 0; m < 8; m++) begin
            oscModeConfig <= m[2:0];
            e = {m[0], m == 4 || m == 6, m[1] ? 6'h20 : 6'h1f};
            bus(1, scc_pkg::OFS_TUNE, {24'h0, m[0], 1'b1, m[1] ? 6'h20 : 6'h1f});
            repeat (2) @(posedge clk);
            chk({24'h0, lowFreqSourceSelect, multiplierEnable, fastRcTrim}, {24'h0, e});
            bus(0, scc_pkg::OFS_TUNE, 32'h0);
            chk(rdv, {24'h0, e});
            // Multiplier is dropped before the mode moves so it never outlives a plain mode
            bus(1, scc_pkg::OFS_TUNE, 32'h0);
            @(posedge clk);
        end
        $display("test tuning done");
    endtask

    task automatic t_switch;
        bus(1, scc_pkg::OFS_IRQ_MASK, 32'h0);
        bus(1, scc_pkg::OFS_IRQ_STAT, 32'hf);
        for (int i = 0; i < 6; i++) begin
            defaultSourceConfig <= dfTbl[i];
            bus(1, scc_pkg::OFS_CTRL, {24'h0, 6'h10, selTbl[i]});
            wait_switch();
            chk({30'h0, activeSource}, {30'h0, expTbl[i]});
            repeat (2) @(posedge clk);
            chk({31'h0, secondaryClockRunning}, {31'h0, expTbl[i] == 2'h1});
            if (i == 0) begin
                repeat (3) @(posedge clk);
                chk({31'h0, irq}, 32'h0);
                chk({31'h0, primaryStartupDone}, 32'h1);
                bus(0, scc_pkg::OFS_IRQ_STAT, 32'h0);
                chk(rdv & 32'h1, 32'h1);
                bus(1, scc_pkg::OFS_IRQ_MASK, 32'h1);
                repeat (3) @(posedge clk);
                chk({31'h0, irq}, 32'h1);
                bus(1, scc_pkg::OFS_IRQ_STAT, 32'h1);
                repeat (3) @(posedge clk);
                chk({31'h0, irq}, 32'h0);
            end
        end
        bus(0, scc_pkg::OFS_CTRL, 32'h0);
        chk(rdv & 32'h4, 32'h4);
        $display("test source switch done");
    endtask

    task automatic power(input logic idle);
        bus(1, scc_pkg::OFS_CTRL, {24'h0, idle, 7'h43});
        sleepReq <= 1'b1;
        @(posedge clk);
        sleepReq <= 1'b0;
        repeat (2) @(posedge clk);
        chk({30'h0, idleActive, sleepActive}, {30'h0, idle, !idle});
        wakeReq <= 1'b1;
        @(posedge clk);
        wakeReq <= 1'b0;
        repeat (2) @(posedge clk);
        chk({30'h0, idleActive, sleepActive}, 32'h0);
    endtask

    task automatic t_sleep;
        power(1'b1);
        power(1'b0);
        secondaryOscEnable <= 1'b0;
        bus(1, scc_pkg::OFS_IRQ_MASK, 32'h8);
        bus(1, scc_pkg::OFS_IRQ_STAT, 32'hf);
        bus(1, scc_pkg::OFS_CTRL, 32'h41);
        sleepReq <= 1'b1;
        @(posedge clk);
        sleepReq <= 1'b0;
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(0, scc_pkg::OFS_IRQ_STAT, 32'h0);
        chk(rdv & 32'h8, 32'h8);
        bus(1, scc_pkg::OFS_IRQ_STAT, 32'h8);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wakeReq <= 1'b1;
        @(posedge clk);
        wakeReq <= 1'b0;
        secondaryOscEnable <= 1'b1;
        $display("test sleep done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sysRst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        oscModeConfig = 3'h0;
        defaultSourceConfig = 1'b0;
        twoSpeedStartupConfig = 1'b1;
        secondaryOscEnable = 1'b1;
        sleepReq = 1'b0;
        wakeReq = 1'b0;
        repeat (6) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_freq();
        t_tune();
        t_switch();
        t_sleep();
        tally_and_finish();
    end
endmodule
